// [core/frs_regs.sv]
// rate select, tape/drive type and main status registers of the floppy controller
`timescale 1ns/1ps
`include "frs_defines.svh"
// Notes on behaviour
// [RULE1] tape register: tape select 1:0, boot drive 3:2, drive type 5:4, 7:6 reserved
// [RULE2] drive type picked from config byte pair indexed by drive select
// [RULE3] rate select is write-only; rate follows latest rate select or config write
// [RULE4] rate select survives software reset; hardware reset loads 02h
// [RULE5] bits 4:2 pick write shift: 111 none, 001-110 steps, 000 default
// [RULE6] default shift: 20.8 ns at 2M, 41.67 ns at 1M, else 125 ns
// [RULE7] shifting starts at configured track, track 0 by default
// [RULE8] bit 6 enters low power; soft reset or data/status access leaves it
// [RULE9] bit 7 resets controller like output reset bit, then clears itself
// [RULE10] every rate select write copied into readable shadow byte
// [RULE11] rate decode per select and drive rate; density high at 1M and 500K
// [RULE12] drive density pins mapped from drive type bits
// [RULE13] main status read-only, readable any time, bits 3:2 zero
// [RULE14] host polls main status before each polled data byte
// [RULE15] bits 1:0 show drive seeking
// [RULE16] bit 4 shows command in progress
// [RULE17] bit 5 shows polled execution phase
// [RULE18] bit 6 gives transfer direction
// [RULE19] bit 7 shows data register ready; host waits while clear
// [RULE20] output register drive select is binary, indexes drive type
// [RULE21] output reset bit holds reset from 0 until 1, leaves rates alone
// [RULE22] one two-bit active rate register; density outputs decoded from it
// [RULE23] self-clearing reset lasts at least one clock cycle
module frs_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input frs_pkg::frs_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic io_rdata_hit,
  input frs_pkg::frs_fdc_stat_t fdc_stat,
  input wire logic enhanced_mode2,
  input wire logic [1:0] boot_drive,
  input wire logic [7:0] cfg_drive_types,
  input wire logic drive_rate_bit0,
  input wire logic drive_rate_bit1,
  input wire logic wdata_in,
  input wire logic [7:0] cur_track,
  input wire logic [7:0] write_shift_select_start_track,
  output logic wdata_out,
  output logic [1:0] rate_select_bits,
  output logic density_select,
  output logic drive_density_out0,
  output logic drive_density_out1,
  output logic [1:0] drive_sel,
  output logic [7:0] rate_shadow,
  output logic low_power,
  output logic ctrl_reset
);
  import frs_pkg::*;

  localparam logic [3:0] SRST_CYC = 4'(`FRS_SRST_CYC);

  frs_state_t st_reg;
  frs_state_t st_next;

  // ==========================================
  // address decode
  logic acc_rs;
  logic acc_td;
  logic acc_oc;
  logic acc_data;
  logic acc_cr;
  assign acc_rs = io_req.addr == `FRS_OFS_RATE_STATUS;
  assign acc_td = io_req.addr == `FRS_OFS_TAPE_DRIVE;
  assign acc_oc = io_req.addr == `FRS_OFS_OUTPUT_CTRL;
  assign acc_data = io_req.addr == `FRS_OFS_DATA;
  assign acc_cr = io_req.addr == `FRS_OFS_CFG_RATE;

  // ==========================================
  // decode helpers
  logic [1:0] drive_type;
  logic [7:0] status_byte;
  logic [7:0] tape_byte;
  assign drive_type = cfg_drive_types[{st_reg.drive_sel, 1'b0} +: 2]; // [RULE2] [RULE20]

  always_comb begin
    status_byte = '0;
    status_byte[7] = fdc_stat.request_for_master; // [RULE19]
    status_byte[6] = fdc_stat.transfer_direction; // [RULE18]
    status_byte[5] = fdc_stat.polled_execution_flag; // [RULE17]
    status_byte[4] = fdc_stat.cmd_busy; // [RULE16]
    status_byte[1] = fdc_stat.drive_b_seeking; // [RULE15]
    status_byte[0] = fdc_stat.drive_a_seeking; // [RULE15]
  end

  always_comb begin
    // plain mode shows only tape select; upper bits read zero
    tape_byte = '0;
    tape_byte[`FRS_TDT_TAPE_LO +: 2] = st_reg.tape_sel;
    if (enhanced_mode2) begin // [RULE1]
      tape_byte[`FRS_TDT_BOOT_LO +: 2] = boot_drive;
      tape_byte[`FRS_TDT_TYPE_LO +: 2] = drive_type;
    end
  end

  // ==========================================
  // next state
  always_comb begin
    logic [1:0] r;
    logic dens;
    logic [1:0] dt;
    r = '0;
    dens = 1'b0;
    dt = '0;
    st_next = st_reg;
    st_next.rdata_hit = 1'b0;

    // host writes
    if (io_req.wr && acc_rs) begin
      st_next.rate_select_control = io_req.wdata; // [RULE10]
      st_next.rate_select_bits = io_req.wdata[`FRS_RSC_RATE_LO +: 2]; // [RULE3] [RULE22]
      if (io_req.wdata[`FRS_RSC_LOWPWR]) begin
        st_next.low_power = 1'b1; // [RULE8]
      end
      if (io_req.wdata[`FRS_RSC_SWRESET]) begin
        st_next.srst_cnt = SRST_CYC; // [RULE9] [RULE23]
      end
    end
    if (io_req.wr && acc_cr) begin
      st_next.rate_select_bits = io_req.wdata[1:0]; // [RULE3] [RULE22]
    end
    if (io_req.wr && acc_oc) begin
      st_next.output_control_register = io_req.wdata;
      st_next.drive_sel = io_req.wdata[`FRS_OCR_SEL_LO +: 2]; // [RULE20]
    end
    if (io_req.wr && acc_td) begin
      st_next.tape_sel = io_req.wdata[`FRS_TDT_TAPE_LO +: 2];
    end

    // host reads; rate select itself is never readable here
    if (io_req.rd) begin
      st_next.rdata_hit = acc_rs || acc_td || acc_oc;
      if (acc_rs) begin
        st_next.rdata = status_byte; // [RULE13]
      end else if (acc_td) begin
        st_next.rdata = tape_byte;
      end else if (acc_oc) begin
        st_next.rdata = st_reg.output_control_register;
      end else begin
        st_next.rdata = '0;
      end
    end

    // self-clearing reset count
    if (st_reg.srst_cnt != '0) begin
      st_next.srst_cnt = st_reg.srst_cnt - 4'h1;
      if (st_reg.srst_cnt == 4'h1) begin
        st_next.rate_select_control[`FRS_RSC_SWRESET] = 1'b0; // [RULE9]
      end
    end

    // reset held by output bit or pending self-clearing pulse
    st_next.ctrl_reset = !st_next.output_control_register[`FRS_OCR_NRESET]
      || (st_next.srst_cnt != '0); // [RULE21] [RULE9]

    // leaving low power wins over entering it in the same cycle
    if (st_next.ctrl_reset
        || ((io_req.rd || io_req.wr) && acc_data)
        || (io_req.rd && acc_rs)) begin
      st_next.low_power = 1'b0; // [RULE8]
    end

    // density and drive density from the next rate
    r = st_next.rate_select_bits;
    dens = (r == 2'h3) || (r == 2'h0); // [RULE11]
    dt = drive_type;
    if (io_req.wr && acc_oc) begin
      dt = cfg_drive_types[{io_req.wdata[1:0], 1'b0} +: 2];
    end
    st_next.density_select = dens;
    case (dt) // [RULE12]
      2'h0: begin
        st_next.drive_density_out1 = r[0];
        st_next.drive_density_out0 = dens;
      end
      2'h2: begin
        st_next.drive_density_out1 = r[0];
        st_next.drive_density_out0 = r[1];
      end
      2'h1: begin
        st_next.drive_density_out1 = r[0];
        st_next.drive_density_out0 = !dens;
      end
      default: begin
        st_next.drive_density_out1 = r[1];
        st_next.drive_density_out0 = r[0];
      end
    endcase
  end

  // ==========================================
  // state register; only a hardware reset reaches the rate bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.rate_select_control <= `FRS_RSC_RESET; // [RULE4]
      st_reg.rate_select_bits <= `FRS_RATE_RESET; // [RULE4]
      st_reg.output_control_register <= `FRS_OCR_RESET;
      st_reg.ctrl_reset <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // rate kind for precompensation
  logic rate_is_2m;
  logic rate_is_1m;
  assign rate_is_1m = st_reg.rate_select_bits == 2'h3; // [RULE11]
  assign rate_is_2m = (st_reg.rate_select_bits == 2'h1) && drive_rate_bit1
    && !drive_rate_bit0; // [RULE11]

  frs_write_shift_select #(
    .DEPTH(16)
  ) u_write_shift_select (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wdata_in(wdata_in),
    .write_shift_select(st_reg.rate_select_control[`FRS_RSC_SHIFT_LO +: 3]),
    .rate_is_2m(rate_is_2m),
    .rate_is_1m(rate_is_1m),
    .cur_track(cur_track),
    .start_track(write_shift_select_start_track),
    .wdata_out(wdata_out)
  );

  // ==========================================
  // outputs
  assign io_rdata = st_reg.rdata;
  assign io_rdata_hit = st_reg.rdata_hit;
  assign rate_select_bits = st_reg.rate_select_bits;
  assign density_select = st_reg.density_select;
  assign drive_density_out0 = st_reg.drive_density_out0;
  assign drive_density_out1 = st_reg.drive_density_out1;
  assign drive_sel = st_reg.drive_sel;
  assign rate_shadow = st_reg.rate_select_control;
  assign low_power = st_reg.low_power;
  assign ctrl_reset = st_reg.ctrl_reset;
endmodule

// [inc/frs_defines.svh]
// offsets, field positions, reset values and timing counts of the rate/status registers
`ifndef FRS_DEFINES_SVH
`define FRS_DEFINES_SVH
// ==========================================
// register offsets on the 8-bit i/o bus
`define FRS_ADDR_W 10
`define FRS_OFS_OUTPUT_CTRL 10'h3F2
`define FRS_OFS_TAPE_DRIVE 10'h3F3
`define FRS_OFS_RATE_STATUS 10'h3F4
`define FRS_OFS_DATA 10'h3F5
`define FRS_OFS_CFG_RATE 10'h3F7
// ==========================================
// field positions
`define FRS_RSC_SWRESET 7
`define FRS_RSC_LOWPWR 6
`define FRS_RSC_SHIFT_LO 2
`define FRS_RSC_RATE_LO 0
`define FRS_OCR_NRESET 2
`define FRS_OCR_SEL_LO 0
`define FRS_TDT_TAPE_LO 0
`define FRS_TDT_BOOT_LO 2
`define FRS_TDT_TYPE_LO 4
// ==========================================
// reset values
`define FRS_RSC_RESET 8'h02
`define FRS_OCR_RESET 8'h00
`define FRS_RATE_RESET 2'h2
`define FRS_SHIFT_ZERO 3'h7
`define FRS_SHIFT_DEFAULT 3'h0
// ==========================================
// timing
`define FRS_CLK_PS 20000
`define FRS_SRST_NS 100
`define FRS_SRST_CYC ((`FRS_SRST_NS * 1000 + `FRS_CLK_PS - 1) / `FRS_CLK_PS)
`define FRS_STEP_PS 41670
`define FRS_STEP_2M_PS 20800
`define FRS_DEF_2M_PS 20800
`define FRS_DEF_1M_PS 41670
`define FRS_DEF_LOW_PS 125000
`endif

// [inc/frs_pkg.sv]
// types shared by the rate/status register block
package frs_pkg;
  // ==========================================
  // host i/o request, one access per strobe
  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } frs_io_req_t;
  // ==========================================
  // live status from the command engine
  typedef struct packed {
    logic request_for_master;
    logic transfer_direction;
    logic polled_execution_flag;
    logic cmd_busy;
    logic drive_b_seeking;
    logic drive_a_seeking;
  } frs_fdc_stat_t;
  // ==========================================
  // precompensation delay line state
  typedef struct packed {
    logic [15:0] line;
    logic wdata_out;
  } frs_pc_state_t;
  // ==========================================
  // register block state
  typedef struct packed {
    logic [7:0] rate_select_control;
    logic [7:0] output_control_register;
    logic [1:0] tape_sel;
    logic [1:0] rate_select_bits;
    logic low_power;
    logic [3:0] srst_cnt;
    logic ctrl_reset;
    logic [7:0] rdata;
    logic rdata_hit;
    logic density_select;
    logic drive_density_out0;
    logic drive_density_out1;
    logic [1:0] drive_sel;
  } frs_state_t;
endpackage

// [core/frs_write_shift_select.sv]
// write precompensation delay line on the write data stream
`timescale 1ns/1ps
`include "frs_defines.svh"
module frs_write_shift_select #(
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wdata_in,
  input wire logic [2:0] write_shift_select,
  input wire logic rate_is_2m,
  input wire logic rate_is_1m,
  input wire logic [7:0] cur_track,
  input wire logic [7:0] start_track,
  output logic wdata_out
);
  import frs_pkg::*;

  // 250 ns at 20 ns cycles needs 13 taps
  if (DEPTH < 16 || DEPTH > 16) begin : g_chk
    $error("frs_write_shift_select: DEPTH must be 16");
  end

  frs_pc_state_t st_reg;
  frs_pc_state_t st_next;

  // ==========================================
  // delay selection
  always_comb begin
    int delay_ps;
    int taps;
    delay_ps = 0;
    taps = 0;
    st_next = st_reg;
    if (write_shift_select == `FRS_SHIFT_DEFAULT) begin // [RULE6]
      if (rate_is_2m) begin
        delay_ps = `FRS_DEF_2M_PS;
      end else if (rate_is_1m) begin
        delay_ps = `FRS_DEF_1M_PS;
      end else begin
        delay_ps = `FRS_DEF_LOW_PS;
      end
    end else if (write_shift_select != `FRS_SHIFT_ZERO) begin // [RULE5]
      delay_ps = int'(write_shift_select) * (rate_is_2m ? `FRS_STEP_2M_PS : `FRS_STEP_PS);
    end
    // tracks below the configured start get no shift
    if (cur_track < start_track) begin // [RULE7]
      delay_ps = 0;
    end
    // nearest whole cycle; finer shifts need a faster clock
    taps = (delay_ps + `FRS_CLK_PS / 2) / `FRS_CLK_PS;
    st_next.line = {st_reg.line[14:0], wdata_in};
    if (taps == 0) begin
      st_next.wdata_out = wdata_in;
    end else begin
      st_next.wdata_out = st_reg.line[4'(taps - 1)]; // [RULE5]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wdata_out = st_reg.wdata_out;
endmodule

// [bench/frs_regs_chk.sv]
// assertion checker for the rate/status register block
`timescale 1ns/1ps
module frs_regs_chk (
  input logic ref_clk,
  input logic arst_n,
  input frs_pkg::frs_io_req_t io_req,
  input logic [7:0] io_rdata,
  input logic io_rdata_hit,
  input frs_pkg::frs_fdc_stat_t fdc_stat,
  input logic enhanced_mode2,
  input logic [1:0] boot_drive,
  input logic [7:0] cfg_drive_types,
  input logic [1:0] rate_select_bits,
  input logic density_select,
  input logic drive_density_out0,
  input logic drive_density_out1,
  input logic [1:0] drive_sel,
  input logic [7:0] rate_shadow,
  input logic low_power,
  input logic ctrl_reset
);
  import frs_pkg::*;
  // ====================
  // decoded strobes, expected drive density pins
  logic rd3, rd4, wr4;
  logic [1:0] ty;
  logic [1:0] dd;
  assign rd3 = io_req.rd && io_req.addr == 10'h3F3;
  assign rd4 = io_req.rd && io_req.addr == 10'h3F4;
  assign wr4 = io_req.wr && io_req.addr == 10'h3F4;
  assign ty = cfg_drive_types[{drive_sel, 1'b0} +: 2];
  always_comb begin
    case (ty)
      2'h0: dd = {rate_select_bits[0], density_select};
      2'h1: dd = {rate_select_bits[0], !density_select};
      2'h2: dd = {rate_select_bits[0], rate_select_bits[1]};
      default: dd = {rate_select_bits[1], rate_select_bits[0]};
    endcase
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ====================
  // properties
  chk_status_read: assert property (rd4 |=> io_rdata_hit &&
    io_rdata == {$past(fdc_stat[5:2]), 2'h0, $past(fdc_stat[1:0])}) else $error("status byte");
  chk_tape_read: assert property (rd3 && enhanced_mode2 |=>
    io_rdata[7:2] == {2'h0, $past(ty), $past(boot_drive)}) else $error("tape byte");
  chk_rate_write: assert property (wr4 && !io_req.wdata[7] |=>
    rate_shadow == $past(io_req.wdata) && rate_select_bits == $past(io_req.wdata[1:0]))
    else $error("rate write");
  chk_cfg_rate: assert property (io_req.wr && io_req.addr == 10'h3F7 |=>
    rate_select_bits == $past(io_req.wdata[1:0])) else $error("cfg rate");
  chk_density_map: assert property (
    density_select == (rate_select_bits[1] == rate_select_bits[0])) else $error("density");
  chk_drive_dens: assert property ($past(arst_n) && $stable(cfg_drive_types) |->
    {drive_density_out1, drive_density_out0} == dd) else $error("drive density");
  chk_lp_set: assert property (wr4 && io_req.wdata[7:6] == 2'h1 && !ctrl_reset |=>
    low_power) else $error("low power set");
  chk_lp_clear: assert property (rd4 || (io_req.rd || io_req.wr) && io_req.addr == 10'h3F5
    |=> !low_power) else $error("low power clear");
  chk_soft_reset: assert property (wr4 && io_req.wdata[7] |=>
    ctrl_reset [*5] ##[1:2] !rate_shadow[7]) else $error("soft reset");
  chk_ocr_write: assert property (io_req.wr && io_req.addr == 10'h3F2 |=>
    drive_sel == $past(io_req.wdata[1:0]) && (ctrl_reset || $past(io_req.wdata[2])))
    else $error("output control");
  cov_soft_reset: cover property (wr4 && io_req.wdata[7]);
  cov_tape_mode2: cover property (rd3 && enhanced_mode2);
  cov_lp_exit: cover property (low_power ##1 !low_power);
endmodule
bind frs_regs frs_regs_chk i_chk (.*);

// [bench/frs_host.sv]
// host processor model on the 8-bit i/o bus
`timescale 1ns/1ps
module frs_host (
  input logic ref_clk,
  output frs_pkg::frs_io_req_t io_req,
  input logic [7:0] io_rdata
);
  import frs_pkg::*;
  initial io_req = '0;
  // ====================
  // one access: strobe taken at the next edge, then released
  task automatic xfer(input logic rd, input logic [9:0] addr, input logic [7:0] wdata,
    output logic [7:0] q);
    @(posedge ref_clk);
    io_req <= {rd, !rd, addr, wdata};
    @(posedge ref_clk);
    // idle bus shows inverted values, never the stale request
    io_req <= {2'h0, ~addr, ~wdata};
    #1;
    q = io_rdata;
  endtask
  // ====================
  // data byte: status polled first, bounded so a stuck engine cannot hang us
  task automatic data_byte(input logic rd, input logic [7:0] wdata, output logic [7:0] q);
    logic [7:0] st;
    int n;
    st = 8'h00;
    n = 0;
    q = 8'h00;
    while (!st[7] && n < 16) begin
      xfer(1'b1, 10'h3F4, 8'h00, st);
      n++;
    end
    if (st[7]) xfer(rd, 10'h3F5, wdata, q);
  endtask
endmodule

// [bench/testbench.sv]
// self-checking testbench for the rate/status register block
`timescale 1ns/1ps
module testbench;
  import frs_pkg::*;
  logic ref_clk, arst_n, enhanced_mode2, wdata_in, io_rdata_hit, wdata_out, density_select;
  logic drive_rate_bit0, drive_rate_bit1, drive_density_out0, drive_density_out1;
  logic low_power, ctrl_reset;
  logic [1:0] boot_drive, rate_select_bits, drive_sel;
  logic [7:0] cfg_drive_types, cur_track, write_shift_select_start_track, io_rdata, rate_shadow;
  frs_io_req_t io_req;
  frs_fdc_stat_t fdc_stat;
  int bad_count, checks_done, cyc;
  frs_regs i_dut (.*);
  frs_host i_host (.*);
  // ====================
  // checking and closing
  task automatic cmp(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [1:0] dd_exp(logic [1:0] t, logic [1:0] r);
    logic d;
    d = r[1] == r[0];
    case (t)
      2'h0: return {r[0], d};
      2'h1: return {r[0], !d};
      2'h2: return {r[0], r[1]};
      default: return {r[1], r[0]};
    endcase
  endfunction
  // delays rounded to whole 20 ns cycles plus the output flop
  function automatic int dly_exp(logic [2:0] c, logic [1:0] r);
    if (c == 3'h7) return 1;
    if (c == 3'h0) return (r == 2'h3) ? 3 : 7;
    return (c * 41670 + 10000) / 20000 + 1;
  endfunction
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // ====================
  // main sequence
  initial begin
    logic [7:0] q, v;
    logic [1:0] rt, ty;
    int n;
    void'($urandom(87));
    {arst_n, enhanced_mode2, wdata_in, boot_drive, drive_rate_bit0, drive_rate_bit1} = '0;
    cfg_drive_types = 8'h00;
    fdc_stat = '0;
    cur_track = 8'h10;
    write_shift_select_start_track = 8'h05;
    rt = 2'h2;
    repeat (10) @(posedge ref_clk);
    #1 cmp({rate_shadow[3:0], rate_select_bits, density_select, ctrl_reset}, 8'h29);
    @(posedge ref_clk) arst_n <= 1'b1;
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      cfg_drive_types <= 8'($urandom);
      boot_drive <= 2'($urandom);
      enhanced_mode2 <= 1'b1;
      i_host.xfer(1'b0, 10'h3F3, 8'(s), q);
      i_host.xfer(1'b0, 10'h3F2, 8'(s + 4), q);
      i_host.xfer(1'b1, 10'h3F3, 8'h00, q);
      ty = cfg_drive_types[2 * s +: 2];
      cmp(q, {2'h0, ty, boot_drive, 2'(s)});
      cmp({6'h0, drive_sel}, 8'(s));
      cmp({6'h0, drive_density_out1, drive_density_out0}, {6'h0, dd_exp(ty, rt)});
    end
    @(posedge ref_clk) enhanced_mode2 <= 1'b0;
    i_host.xfer(1'b1, 10'h3F3, 8'h00, q);
    cmp(q, 8'h03);
    $display("test drive type done");
    for (n = 0; n < 24; n++) begin
      v = 8'($urandom) & (n[0] ? 8'h03 : 8'h5F);
      @(posedge ref_clk);
      fdc_stat <= 6'($urandom);
      {drive_rate_bit1, drive_rate_bit0} <= 2'($urandom);
      i_host.xfer(1'b0, n[0] ? 10'h3F7 : 10'h3F4, v, q);
      rt = v[1:0];
      if (!n[0]) cmp(rate_shadow, v);
      cmp({rate_select_bits, density_select, low_power, drive_density_out1, drive_density_out0,
        2'h0}, {rt, rt[1] == rt[0], v[6], dd_exp(ty, rt), 2'h0});
      i_host.xfer(1'b1, 10'h3F4, 8'h00, q);
      cmp(q, {fdc_stat[5:2], 2'h0, fdc_stat[1:0]});
      cmp({io_rdata_hit, low_power, 6'h0}, 8'h80);
    end
    $display("test rate and status done");
    i_host.xfer(1'b0, 10'h3F4, 8'hC1, q);
    cmp({6'h0, ctrl_reset, low_power}, 8'h02);
    repeat (6) @(posedge ref_clk);
    #1 cmp({rate_shadow[6:0], ctrl_reset}, 8'h82);
    i_host.xfer(1'b0, 10'h3F2, 8'h03, q);
    cmp({5'h0, rate_select_bits, ctrl_reset}, 8'h03);
    i_host.xfer(1'b0, 10'h3F2, 8'h07, q);
    cmp({7'h0, ctrl_reset}, 8'h00);
    @(posedge ref_clk) fdc_stat <= 6'h20;
    i_host.xfer(1'b0, 10'h3F4, 8'h42, q);
    cmp({7'h0, low_power}, 8'h01);
    i_host.data_byte(1'b0, 8'hA5, q);
    i_host.xfer(1'b1, 10'h3F7, 8'h00, q);
    cmp({q[5:0], io_rdata_hit, low_power}, 8'h00);
    $display("test reset paths done");
    for (int i = 0; i < 10; i++) begin
      v = (i < 8) ? {3'h0, 3'(i), 2'h2} : ((i == 8) ? 8'h03 : 8'h0E);
      @(posedge ref_clk) cur_track <= (i == 9) ? 8'h02 : 8'h10;
      i_host.xfer(1'b0, 10'h3F4, v, q);
      @(posedge ref_clk) wdata_in <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk) wdata_in <= 1'b0;
        n++;
        #1;
      end while (wdata_out !== 1'b1 && n < 40);
      cmp(8'(n), (i == 9) ? 8'h01 : 8'(dly_exp(v[4:2], v[1:0])));
    end
    $display("test write_shift_select done");
    finish_test();
  end
endmodule
